// *** rtl/bridge_arb_pkg.sv ***
package bridge_arb_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int NUM_CHAN = 16;
    localparam int NUM_NAND = 8;

    // Consecutive processor losses after which priority turns round
    localparam logic [1:0] LOCKOUT_MAX = 2'h3;
    localparam logic [1:0] LOCKOUT_RESET = 2'h0;

    // Channels with a peripheral behind them; the upper eight are empty
    localparam logic [NUM_CHAN-1:0] CHAN_PRESENT = 16'h00FF;
    localparam logic [3:0] NAND_FIRST_CH = 4'h0;
    localparam logic [3:0] RR_PTR_RESET = 4'h0;

    localparam logic HREADY_RESET = 1'b1;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } xfer_cmd_t;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pbus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_ACCESS = 2'b10
    } pbus_state_t;

endpackage

// *** rtl/bridge_arbiter.sv ***
`timescale 1ns/1ns
module bridge_arbiter
    import bridge_arb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Processor side, AHB slave
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [DATA_W-1:0] hwdata,
    output logic hready,
    output logic [DATA_W-1:0] hrdata,
    // DMA channels
    input wire logic [NUM_CHAN-1:0] dma_req,
    input wire xfer_cmd_t [NUM_CHAN-1:0] dma_cmd,
    output logic [NUM_CHAN-1:0] dma_ack,
    output logic [DATA_W-1:0] dma_rdata,
    // Shared peripheral bus
    output pbus_req_t hclk_peripheral_bus,
    output logic [NUM_NAND-1:0] nand_port_sel,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready
);

    pbus_state_t state_reg, state_next;
    pbus_req_t pbus_reg, pbus_next;
    logic owner_dma_reg;
    logic [3:0] chan_reg;
    logic [3:0] rr_ptr_reg;
    logic [1:0] lock_reg, lock_next;
    logic hready_reg;
    logic [DATA_W-1:0] hrdata_reg;
    logic pio_pend_reg;
    logic pio_wait_data_reg;
    xfer_cmd_t pio_cmd_reg;
    logic [NUM_CHAN-1:0] dma_ack_reg;
    logic [DATA_W-1:0] dma_rdata_reg;
    logic [NUM_NAND-1:0] nand_sel_reg;

    function automatic logic [3:0] next_chan(input logic [NUM_CHAN-1:0] req,
                                             input logic [3:0] ptr);
        logic [3:0] idx;
        logic found;
        next_chan = ptr;
        found = 1'b0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            idx = ptr + 4'(i);
            if (!found && req[idx]) begin
                next_chan = idx;
                found = 1'b1;
            end
        end
    endfunction

    // Decode and arbitration
    wire ahb_take = hsel && htrans[1] && hready_reg;
    wire pio_ready = pio_pend_reg && !pio_wait_data_reg;
    // Empty channels are never granted, so a stray request there cannot stall the bus
    wire [NUM_CHAN-1:0] dma_live = dma_req & CHAN_PRESENT;
    wire dma_any = |dma_live;
    wire [3:0] dma_pick = next_chan(dma_live, rr_ptr_reg);
    wire lock_full = (lock_reg == LOCKOUT_MAX);
    wire pick_pio = pio_ready && (!dma_any || lock_full);
    wire pick_dma = dma_any && !pick_pio;
    wire arb_start = (state_reg == ST_IDLE) && (pick_pio || pick_dma);
    wire xfer_done = (state_reg == ST_ACCESS) && pready;
    wire pio_done = xfer_done && !owner_dma_reg;
    wire dma_done = xfer_done && owner_dma_reg;
    wire xfer_cmd_t start_cmd = pick_pio ? pio_cmd_reg : dma_cmd[dma_pick];
    wire [NUM_CHAN-1:0] chan_onehot = NUM_CHAN'(1) << chan_reg;
    wire [NUM_NAND-1:0] nand_onehot = NUM_NAND'(1) << dma_pick[2:0];

    // Lockout counter; saturation comes from the processor winning at the top
    always_comb begin
        lock_next = lock_reg;
        if (arb_start && pick_pio) begin
            lock_next = LOCKOUT_RESET;
        end else if (arb_start && pio_ready) begin
            lock_next = lock_reg + 2'h1;
        end
    end

    // Peripheral bus sequence: setup, then access until pready
    always_comb begin
        state_next = state_reg;
        pbus_next = pbus_reg;
        case (state_reg)
            ST_IDLE: begin
                if (arb_start) begin
                    state_next = ST_SETUP;
                    pbus_next = {1'b1, 1'b0, start_cmd};
                end
            end
            ST_SETUP: begin
                state_next = ST_ACCESS;
                pbus_next.enable = 1'b1;
            end
            ST_ACCESS: begin
                if (pready) begin
                    state_next = ST_IDLE;
                    pbus_next.sel = 1'b0;
                    pbus_next.enable = 1'b0;
                end
            end
            default: begin
                state_next = ST_IDLE;
                pbus_next.sel = 1'b0;
                pbus_next.enable = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            pbus_reg <= '0;
            lock_reg <= LOCKOUT_RESET;
        end else begin
            state_reg <= state_next;
            pbus_reg <= pbus_next;
            lock_reg <= lock_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            owner_dma_reg <= 1'b0;
            chan_reg <= RR_PTR_RESET;
            rr_ptr_reg <= RR_PTR_RESET;
            nand_sel_reg <= '0;
        end else if (arb_start) begin
            owner_dma_reg <= pick_dma;
            chan_reg <= dma_pick;
            nand_sel_reg <= (pick_dma && dma_pick < 4'(NUM_NAND)) ? nand_onehot : '0;
        end else if (xfer_done) begin
            nand_sel_reg <= '0;
            if (owner_dma_reg) begin
                rr_ptr_reg <= chan_reg + 4'h1;
            end
        end
    end

    // AHB slave: wait states until the peripheral transfer finishes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hready_reg <= HREADY_RESET;
            pio_pend_reg <= 1'b0;
            pio_wait_data_reg <= 1'b0;
            pio_cmd_reg <= '0;
            hrdata_reg <= '0;
        end else begin
            pio_wait_data_reg <= ahb_take;
            if (ahb_take) begin
                hready_reg <= 1'b0;
                pio_pend_reg <= 1'b1;
                pio_cmd_reg.write <= hwrite;
                pio_cmd_reg.addr <= haddr;
            end else if (pio_done) begin
                hready_reg <= 1'b1;
                pio_pend_reg <= 1'b0;
                hrdata_reg <= prdata;
            end
            // Write data follows one cycle behind the address phase
            if (pio_wait_data_reg) begin
                pio_cmd_reg.wdata <= hwdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            dma_ack_reg <= '0;
            dma_rdata_reg <= '0;
        end else begin
            dma_ack_reg <= dma_done ? chan_onehot : '0;
            if (dma_done) begin
                dma_rdata_reg <= prdata;
            end
        end
    end

    assign hready = hready_reg;
    assign hrdata = hrdata_reg;
    assign dma_ack = dma_ack_reg;
    assign dma_rdata = dma_rdata_reg;
    assign hclk_peripheral_bus = pbus_reg;
    assign nand_port_sel = nand_sel_reg;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    access_after_setup_a: assert property (
        $rose(pbus_reg.enable) |-> $past(pbus_reg.sel) && !$past(pbus_reg.enable)
                                   && pbus_reg.sel)
        else $error("enable rose without a setup cycle");

    single_owner_a: assert property (
        xfer_done |=> !(hready_reg && !$past(hready_reg) && (|dma_ack_reg)))
        else $error("processor and DMA completed together");

    dma_wins_a: assert property (
        (state_reg == ST_IDLE) && dma_any && pio_ready && !lock_full
        |=> owner_dma_reg && state_reg == ST_SETUP)
        else $error("DMA not favoured in a conflict");

    wait_low_a: assert property (
        ahb_take || (!hready_reg && !pio_done) |=> !hready_reg)
        else $error("hready released before completion");

    wait_bound_a: assert property (
        pio_ready && (state_reg == ST_IDLE) && !(dma_any && !lock_full) |-> ##[3:40] hready_reg)
        else $error("processor access never completed");

    every_fourth_a: assert property (
        (state_reg == ST_IDLE) && pio_ready && lock_full |=> !owner_dma_reg)
        else $error("processor not granted after three losses");

    ack_onehot_a: assert property (
        dma_done |=> $onehot(dma_ack_reg) && dma_ack_reg == chan_onehot)
        else $error("DMA ack not one channel");

    empty_chan_a: assert property (
        dma_ack_reg[15:8] == 8'h00 && (nand_sel_reg == '0 || owner_dma_reg))
        else $error("empty channel served or NAND select without DMA");

    lock_clear_a: assert property (
        arb_start && pick_pio |=> lock_reg == LOCKOUT_RESET)
        else $error("lockout count not cleared on processor grant");

    pio_alone_c: cover property (pio_done && !dma_any);
    dma_alone_c: cover property (dma_done && !pio_pend_reg);
    inversion_c: cover property (arb_start && pick_pio && dma_any);
    back_to_back_c: cover property (pio_done ##1 ahb_take);

endmodule

// *** tb/pbus_model.sv ***
`timescale 1ns/1ns
module pbus_model
    import bridge_arb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Peripheral bus
    input wire pbus_req_t bus,
    input wire logic slow,
    output logic pready,
    output logic [DATA_W-1:0] prdata
);
    logic [DATA_W-1:0] cnt_reg;
    always_ff @(posedge core_clk) begin
        cnt_reg <= reset ? '0 : cnt_reg + 32'h1;
    end
    // Slow mode stalls every other access cycle
    assign pready = bus.enable & (~slow | cnt_reg[0]);
    // Outside a completing access the data lines wander, so stale data cannot match
    assign prdata = (bus.enable & pready) ? ~bus.addr : cnt_reg ^ 32'hA5A5A5A5;
endmodule

// *** tb/peripheral_bus_bridge_arbiter_test.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module peripheral_bus_bridge_arbiter_test;
    import bridge_arb_pkg::*;
    logic core_clk, reset, hsel, hwrite, hready, pready, slow;
    logic [1:0] htrans;
    logic [ADDR_W-1:0] haddr;
    logic [DATA_W-1:0] hwdata, hrdata, dma_rdata, prdata;
    logic [NUM_CHAN-1:0] want, dma_req, dma_ack;
    xfer_cmd_t [NUM_CHAN-1:0] dma_cmd;
    pbus_req_t pbus;
    logic [NUM_NAND-1:0] nand_sel;
    int miscompares, n_compared, acks;
    // A channel drops its request in its ack cycle
    assign dma_req = want & ~dma_ack;
    bridge_arbiter u_dut(.core_clk(core_clk), .reset(reset), .hsel(hsel), .htrans(htrans),
        .hwrite(hwrite), .haddr(haddr), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .dma_req(dma_req), .dma_cmd(dma_cmd), .dma_ack(dma_ack), .dma_rdata(dma_rdata),
        .hclk_peripheral_bus(pbus), .nand_port_sel(nand_sel), .prdata(prdata),
        .pready(pready));
    pbus_model u_pbus(.core_clk(core_clk), .reset(reset), .bus(pbus), .slow(slow),
        .pready(pready), .prdata(prdata));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task conclude;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task ahb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int i;
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        // Data phase is held until ready is seen high
        for (i = 0; i < 200; i++) begin
            @(posedge core_clk);
            acks += $countones(dma_ack);
            if (i == 0) `CHK(hready, 1'b0)
            if (pbus.enable === 1'b1 && pready === 1'b1 && pbus.addr === a) begin
                `CHK(pbus.write, wr)
                if (wr) `CHK(pbus.wdata, d)
            end
            if (hready === 1'b1) break;
        end
        if (i == 200) begin
            miscompares++;
            conclude();
        end
        if (!wr) `CHK(hrdata, ~a)
    endtask
    task dma_one(input int ch);
        int i;
        @(posedge core_clk);
        want[ch] <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (pbus.sel === 1'b1) `CHK(nand_sel, 8'h1 << ch)
            if (pbus.enable === 1'b1 && pready === 1'b1) begin
                `CHK(pbus.write, dma_cmd[ch].write)
                if (dma_cmd[ch].write) `CHK(pbus.wdata, dma_cmd[ch].wdata)
            end
            if (dma_ack[ch] === 1'b1) break;
        end
        want[ch] <= 1'b0;
        if (ch < 8) begin
            // A served channel that is never acked is a hang
            if (i == 50) begin
                miscompares++;
                conclude();
            end
            `CHK(dma_rdata, ~dma_cmd[ch].addr)
        end
        if (ch >= 8) `CHK(i, 50)
    endtask
    task reset_mid;
        @(posedge core_clk);
        want[3] <= 1'b1;
        repeat (2) @(posedge core_clk);
        // Reset lands in the access cycle, so the ack must never appear
        reset <= 1'b1;
        want <= 16'h0000;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        `CHK(pbus, '0)
        `CHK(nand_sel, 8'h00)
        `CHK(dma_ack, 16'h0000)
        `CHK(hready, 1'b1)
        dma_one(3);
    endtask
    task contend;
        int k;
        @(posedge core_clk);
        want <= 16'h00FF;
        slow <= 1'b1;
        for (k = 0; k < 2; k++) begin
            acks = 0;
            ahb(1'b0, 32'h00000200, 32'h00000000);
            // One transfer may already be in flight when the processor arrives
            `CHK(acks >= 1 && acks <= 4, 1'b1)
        end
        want <= 16'h0000;
        slow <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = '0;
        hwdata = '0;
        want = '0;
        slow = 1'b0;
        for (int c = 0; c < NUM_CHAN; c++) begin
            dma_cmd[c] = '{write: 1'(c % 2), addr: 32'h00001000 + c * 4,
                wdata: 32'hD0000000 + c};
        end
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        `CHK(hready, 1'b1)
        `CHK(dma_ack, 16'h0000)
        ahb(1'b1, 32'h00000010, 32'hCAFE0001);
        ahb(1'b0, 32'h00000014, 32'h00000000);
        dma_one(2);
        dma_one(7);
        dma_one(9);
        contend();
        reset_mid();
        conclude();
    end
endmodule
